// *** hdl/pio_ctrl.sv ***
// Logic-level control port of a syringe pump: trigger decoding, direction
// steering, motor activity and direction outputs, program pin steps.
// Assumes keypad editing, alarm, pause timer and direction-key-allowed
// come from pump logic on pclk; the three input pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none

module pio_ctrl
  import pio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PIO_ADDR_W-1:0] paddr,
  input wire logic [PIO_DATA_W-1:0] pwdata,
  output logic [PIO_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_pin,
  input wire logic dir_pin,
  input wire logic prog_in_pin,
  output logic motor_active_pin,
  output logic dir_out_pin,
  output logic prog_out_pin,
  input wire logic keypad_edit,
  input wire logic alarm,
  input wire logic pause_timer,
  input wire logic dir_key_ok,
  output logic program_run,
  output logic event_trap,
  output logic cond_jump
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pio_trig_mode_type mode;     // trigger_mode_setting
    pio_dir_mode_type dir_mode;  // Reciprocating or paired same direction
    logic motor_opt;             // Motor activity output option
    logic run;                   // Pumping program running
    logic dir;                   // Current direction, high is infuse
    logic motor;                 // Registered motor activity output
    logic prog_out;              // Program output pin level
    logic trap_sticky;           // Event trap seen since last clear
    logic jump_sticky;           // Conditional jump taken since last clear
    logic trap_pulse;            // One-cycle event trap strobe
    logic jump_pulse;            // One-cycle jump strobe
    logic [PIO_DATA_W-1:0] rdata; // Read data, captured in setup phase
  } pio_state_type;

  pio_state_type st_ff;
  pio_state_type nxt_st;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [PIO_SYN_W-1:0] pins_async; // Raw pins gathered in lanes
  logic [PIO_SYN_W-1:0] pin_lvl;    // Synchronised levels
  logic [PIO_SYN_W-1:0] pin_rise;   // One-cycle rising edges
  logic [PIO_SYN_W-1:0] pin_fall;   // One-cycle falling edges

  assign pins_async[PIO_SYN_TRIG] = trig_pin;
  assign pins_async[PIO_SYN_DIR] = dir_pin;
  assign pins_async[PIO_SYN_PROG] = prog_in_pin;

  // Every pin passes two flops before any edge logic looks at it
  pio_sync_edge #(
    .WIDTH(PIO_SYN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(pins_async),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Address decode for the error answer; read data decodes its own addresses
  function automatic logic is_mapped(input logic [PIO_ADDR_W-1:0] a);
    is_mapped = (a == PIO_OFS_CTRL) || (a == PIO_OFS_STATUS) || (a == PIO_OFS_CMD);
  endfunction

  // Toggle request resolved against the current run state
  function automatic logic [1:0] split_toggle(input logic tog, input logic run);
    split_toggle = {tog & run, tog & ~run};
  endfunction

  // ****************************************************************
  // Working signals
  // ****************************************************************
  logic ignore_in;     // Inputs disregarded
  logic bus_setup;     // APB setup phase
  logic bus_wr;        // APB write completing this cycle
  logic t_start;       // Trigger start activation
  logic t_stop;        // Trigger stop activation
  logic t_toggle;      // Trigger start/stop key emulation
  logic k_start;       // Start from software start/stop key
  logic k_stop;        // Stop from software keys
  logic trap_evt;      // Stop redirected to the event trap
  logic any_start;     // Combined start request
  logic any_stop;      // Combined stop request
  logic dir_flip;      // Direction change request
  logic pumping;       // Motor moving in the next state
  logic [PIO_DATA_W-1:0] status_word; // Status register view
  logic [1:0] tog_split; // {stop, start} from a toggle

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    tog_split = 2'b00;
    ignore_in = keypad_edit | alarm;
    bus_setup = psel & ~penable;
    bus_wr = psel & penable & pwrite;
    t_start = 1'b0;
    t_stop = 1'b0;
    t_toggle = 1'b0;
    k_start = 1'b0;
    k_stop = 1'b0;
    trap_evt = 1'b0;
    dir_flip = 1'b0;

    // Trigger decode by mode; toggle activations emulate the start/stop key
    unique case (st_ff.mode)
      PIO_TRIG_FOOT: begin
        t_toggle = pin_fall[PIO_SYN_TRIG];
      end
      PIO_TRIG_FOOT_HOLD: begin
        t_start = pin_fall[PIO_SYN_TRIG];
        t_stop = pin_rise[PIO_SYN_TRIG];
      end
      PIO_TRIG_FOOT_REV: begin
        t_toggle = pin_rise[PIO_SYN_TRIG];
      end
      PIO_TRIG_LEVEL: begin
        t_stop = pin_fall[PIO_SYN_TRIG];
        t_start = pin_rise[PIO_SYN_TRIG];
      end
      PIO_TRIG_START: begin
        t_start = pin_fall[PIO_SYN_TRIG];
      end
      PIO_TRIG_START_REV: begin
        t_start = pin_rise[PIO_SYN_TRIG];
      end
      PIO_TRIG_STOP: begin
        t_stop = pin_fall[PIO_SYN_TRIG];
      end
      PIO_TRIG_STOP_REV: begin
        t_stop = pin_rise[PIO_SYN_TRIG];
      end
      PIO_TRIG_RUN_LOW: begin
        // Level drives the run state continuously
        t_start = ~pin_lvl[PIO_SYN_TRIG];
        t_stop = pin_lvl[PIO_SYN_TRIG];
      end
      PIO_TRIG_RUN_HIGH: begin
        t_start = pin_lvl[PIO_SYN_TRIG];
        t_stop = ~pin_lvl[PIO_SYN_TRIG];
      end
      PIO_TRIG_STOP_LOW: begin
        t_stop = ~pin_lvl[PIO_SYN_TRIG];
      end
      PIO_TRIG_STOP_HIGH: begin
        t_stop = pin_lvl[PIO_SYN_TRIG];
      end
      PIO_TRIG_EVENT_TRAP: begin
        // Foot switch style; the stop half is redirected below
        t_toggle = pin_fall[PIO_SYN_TRIG];
      end
      PIO_TRIG_OFF, PIO_TRIG_BUTTON_EVENT: begin
        // No action from the trigger pin
        t_toggle = 1'b0;
      end
      default: begin
        // Unused code 15 behaves as off
        t_toggle = 1'b0;
      end
    endcase

    // Keypad editing or alarm silences the trigger and direction inputs
    if (ignore_in) begin
      t_start = 1'b0;
      t_stop = 1'b0;
      t_toggle = 1'b0;
    end

    // Toggle becomes a stop when running, a start when stopped
    tog_split = split_toggle(t_toggle, st_ff.run);
    t_stop = t_stop | tog_split[1];
    t_start = t_start | tog_split[0];

    // In event trap mode a trigger stop goes to the trap instead
    if (st_ff.mode == PIO_TRIG_EVENT_TRAP && t_stop) begin
      trap_evt = 1'b1;
      t_stop = 1'b0;
    end

    // Software keys, accepted only on a completing write
    if (bus_wr && paddr == PIO_OFS_CMD) begin
      tog_split = split_toggle(pwdata[PIO_CMD_STARTSTOP_BIT], st_ff.run);
      k_stop = tog_split[1];
      k_start = tog_split[0];
      if (pwdata[PIO_CMD_STOPKEY_BIT]) begin
        // Button event mode turns the stop key into a trap
        if (st_ff.mode == PIO_TRIG_BUTTON_EVENT) begin
          trap_evt = 1'b1;
        end else begin
          k_stop = 1'b1;
        end
      end
      // Direction key, only where the pump allows it
      if (pwdata[PIO_CMD_DIRKEY_BIT] && dir_key_ok) begin
        dir_flip = 1'b1;
      end
      // Output-setting step drives the program output pin
      if (pwdata[PIO_CMD_OUT_BIT]) begin
        nxt_st.prog_out = pwdata[PIO_CMD_OUTLVL_BIT];
      end
    end

    // Stop beats start when both arrive together, the safe choice
    any_stop = t_stop | k_stop;
    any_start = t_start | k_start;
    if (any_stop) begin
      nxt_st.run = 1'b0;
    end else if (any_start) begin
      nxt_st.run = 1'b1;
    end

    // Direction input emulates the direction key
    if (!ignore_in && dir_key_ok) begin
      if (st_ff.dir_mode == PIO_DIR_RECIP) begin
        // Withdraw + fall -> infuse, infuse + rise -> withdraw
        if (st_ff.dir == PIO_WITHDRAW && pin_fall[PIO_SYN_DIR]) begin
          dir_flip = 1'b1;
        end
        if (st_ff.dir == PIO_INFUSE && pin_rise[PIO_SYN_DIR]) begin
          dir_flip = 1'b1;
        end
      end else begin
        // Withdraw + rise -> infuse, infuse + fall -> withdraw
        if (st_ff.dir == PIO_WITHDRAW && pin_rise[PIO_SYN_DIR]) begin
          dir_flip = 1'b1;
        end
        if (st_ff.dir == PIO_INFUSE && pin_fall[PIO_SYN_DIR]) begin
          dir_flip = 1'b1;
        end
      end
    end
    if (dir_flip) begin
      nxt_st.dir = ~st_ff.dir;
    end

    // Motor activity; option 1 also covers the pause timer
    pumping = nxt_st.run & ~pause_timer;
    nxt_st.motor = st_ff.motor_opt ? (pumping | (nxt_st.run & pause_timer)) : pumping;

    // Control register write
    if (bus_wr && paddr == PIO_OFS_CTRL) begin
      nxt_st.mode = pio_trig_mode_type'(pwdata[PIO_CTRL_MODE_LSB +: PIO_MODE_W]);
      nxt_st.dir_mode = pio_dir_mode_type'(pwdata[PIO_CTRL_DIRMODE_BIT]);
      nxt_st.motor_opt = pwdata[PIO_CTRL_MOTOR_BIT];
    end

    // Sticky flags: write one clears, a new event in the same cycle wins
    if (bus_wr && paddr == PIO_OFS_STATUS) begin
      if (pwdata[PIO_ST_TRAP_BIT]) begin
        nxt_st.trap_sticky = 1'b0;
      end
      if (pwdata[PIO_ST_JUMP_BIT]) begin
        nxt_st.jump_sticky = 1'b0;
      end
    end

    // Conditional step jumps when the program input is low
    nxt_st.jump_pulse = bus_wr && (paddr == PIO_OFS_CMD) && pwdata[PIO_CMD_COND_BIT]
      && !pin_lvl[PIO_SYN_PROG];
    if (nxt_st.jump_pulse) begin
      nxt_st.jump_sticky = 1'b1;
    end
    nxt_st.trap_pulse = trap_evt;
    if (trap_evt) begin
      nxt_st.trap_sticky = 1'b1;
    end

    // Status view of the block's own state
    status_word = PIO_RDATA_ZERO;
    status_word[PIO_ST_RUN_BIT] = st_ff.run;
    status_word[PIO_ST_DIR_BIT] = st_ff.dir;
    status_word[PIO_ST_MOTOR_BIT] = st_ff.motor;
    status_word[PIO_ST_TRAP_BIT] = st_ff.trap_sticky;
    status_word[PIO_ST_JUMP_BIT] = st_ff.jump_sticky;
    status_word[PIO_ST_TRIGIN_BIT] = pin_lvl[PIO_SYN_TRIG];
    status_word[PIO_ST_DIRIN_BIT] = pin_lvl[PIO_SYN_DIR];
    status_word[PIO_ST_PROGIN_BIT] = pin_lvl[PIO_SYN_PROG];
    status_word[PIO_ST_IGNORE_BIT] = ignore_in;
    status_word[PIO_ST_PROGOUT_BIT] = st_ff.prog_out;

    // Read data captured in setup so it leaves a flop in the access phase
    if (bus_setup) begin
      nxt_st.rdata = PIO_RDATA_ZERO;
      if (!pwrite && paddr == PIO_OFS_CTRL) begin
        nxt_st.rdata[PIO_CTRL_MODE_LSB +: PIO_MODE_W] = st_ff.mode;
        nxt_st.rdata[PIO_CTRL_DIRMODE_BIT] = st_ff.dir_mode;
        nxt_st.rdata[PIO_CTRL_MOTOR_BIT] = st_ff.motor_opt;
      end else if (!pwrite && paddr == PIO_OFS_STATUS) begin
        nxt_st.rdata = status_word;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.mode <= PIO_RST_MODE;
      st_ff.dir_mode <= PIO_RST_DIRMODE;
      st_ff.motor_opt <= PIO_RST_MOTOR;
      st_ff.run <= 1'b0;
      st_ff.dir <= PIO_RST_DIR;
      st_ff.motor <= 1'b0;
      st_ff.prog_out <= PIO_RST_PROGOUT;
      st_ff.trap_sticky <= 1'b0;
      st_ff.jump_sticky <= 1'b0;
      st_ff.trap_pulse <= 1'b0;
      st_ff.jump_pulse <= 1'b0;
      st_ff.rdata <= PIO_RDATA_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  // Unmapped addresses answer with an error in the access phase
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata = st_ff.rdata;
  assign motor_active_pin = st_ff.motor;
  assign dir_out_pin = st_ff.dir;
  assign prog_out_pin = st_ff.prog_out;
  assign program_run = st_ff.run;
  assign event_trap = st_ff.trap_pulse;
  assign cond_jump = st_ff.jump_pulse;

endmodule
`default_nettype wire

// *** hdl/pio_pkg.sv ***
// Package for the pump logic I/O control block: register map, field
// positions, reset values and the trigger and direction mode codes.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.

package pio_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned PIO_ADDR_W = 8;
  localparam int unsigned PIO_DATA_W = 32;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] PIO_OFS_CTRL = 8'h00;   // Mode settings
  localparam logic [7:0] PIO_OFS_STATUS = 8'h04; // State, sticky flags (W1C)
  localparam logic [7:0] PIO_OFS_CMD = 8'h08;    // Key and step commands

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned PIO_CTRL_MODE_LSB = 0;
  localparam int unsigned PIO_MODE_W = 4;
  localparam int unsigned PIO_CTRL_DIRMODE_BIT = 4;
  localparam int unsigned PIO_CTRL_MOTOR_BIT = 5;

  // ****************************************************************
  // Command register bits (write only, read as zero)
  // ****************************************************************
  localparam int unsigned PIO_CMD_STARTSTOP_BIT = 0; // Start/stop key
  localparam int unsigned PIO_CMD_STOPKEY_BIT = 1;   // Front panel stop key
  localparam int unsigned PIO_CMD_DIRKEY_BIT = 2;    // Direction key
  localparam int unsigned PIO_CMD_COND_BIT = 3;      // Conditional jump step
  localparam int unsigned PIO_CMD_OUT_BIT = 4;       // Output-setting step
  localparam int unsigned PIO_CMD_OUTLVL_BIT = 5;    // Level for that step

  // ****************************************************************
  // Status register bits
  // ****************************************************************
  localparam int unsigned PIO_ST_RUN_BIT = 0;
  localparam int unsigned PIO_ST_DIR_BIT = 1;
  localparam int unsigned PIO_ST_MOTOR_BIT = 2;
  localparam int unsigned PIO_ST_TRAP_BIT = 3;   // Sticky, W1C
  localparam int unsigned PIO_ST_JUMP_BIT = 4;   // Sticky, W1C
  localparam int unsigned PIO_ST_TRIGIN_BIT = 5;
  localparam int unsigned PIO_ST_DIRIN_BIT = 6;
  localparam int unsigned PIO_ST_PROGIN_BIT = 7;
  localparam int unsigned PIO_ST_IGNORE_BIT = 8;
  localparam int unsigned PIO_ST_PROGOUT_BIT = 9;

  // ****************************************************************
  // Synchroniser lanes
  // ****************************************************************
  localparam int unsigned PIO_SYN_W = 3;
  localparam int unsigned PIO_SYN_TRIG = 0;
  localparam int unsigned PIO_SYN_DIR = 1;
  localparam int unsigned PIO_SYN_PROG = 2;

  // ****************************************************************
  // Mode encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    PIO_TRIG_OFF = 4'h0,
    PIO_TRIG_FOOT = 4'h1,
    PIO_TRIG_FOOT_HOLD = 4'h2,
    PIO_TRIG_FOOT_REV = 4'h3,
    PIO_TRIG_LEVEL = 4'h4,
    PIO_TRIG_START = 4'h5,
    PIO_TRIG_START_REV = 4'h6,
    PIO_TRIG_STOP = 4'h7,
    PIO_TRIG_STOP_REV = 4'h8,
    PIO_TRIG_RUN_LOW = 4'h9,
    PIO_TRIG_RUN_HIGH = 4'hA,
    PIO_TRIG_STOP_LOW = 4'hB,
    PIO_TRIG_STOP_HIGH = 4'hC,
    PIO_TRIG_EVENT_TRAP = 4'hD,
    PIO_TRIG_BUTTON_EVENT = 4'hE
  } pio_trig_mode_type;

  typedef enum logic {
    PIO_DIR_RECIP = 1'b0,
    PIO_DIR_DUAL = 1'b1
  } pio_dir_mode_type;

  // Direction coding: high is infuse, as on the direction output
  localparam logic PIO_INFUSE = 1'b1;
  localparam logic PIO_WITHDRAW = 1'b0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam pio_trig_mode_type PIO_RST_MODE = PIO_TRIG_OFF;
  localparam pio_dir_mode_type PIO_RST_DIRMODE = PIO_DIR_RECIP;
  localparam logic PIO_RST_MOTOR = 1'b0;
  localparam logic PIO_RST_DIR = PIO_INFUSE;
  localparam logic PIO_RST_PROGOUT = 1'b0;
  localparam logic [31:0] PIO_RDATA_ZERO = 32'h0000_0000;

endpackage

// *** hdl/pio_sync_edge.sv ***
// Two-flop synchroniser with edge detection for the external input pins.
// Assumes the pins are asynchronous to pclk; level, rise and fall are
// all taken from the second and third flops only.
`timescale 1ns/10ps
`default_nettype none

module pio_sync_edge #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta;  // First stage, read only by the second
    logic [WIDTH-1:0] sync;  // Second stage, safe level
    logic [WIDTH-1:0] prev;  // Delayed copy for edge detection
  } pio_sync_state_type;

  pio_sync_state_type st_ff;
  pio_sync_state_type nxt_st;

  // Shift pins through the chain; one edge per physical transition
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pin_async;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  // Pins idle high (pulled up), so reset to high avoids a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.sync;
  assign rise = st_ff.sync & ~st_ff.prev;
  assign fall = ~st_ff.sync & st_ff.prev;

endmodule
`default_nettype wire

// *** dv/pio_ctrl_checker.sv ***
// Checker for the pump logic I/O control block, bound to pio_ctrl.
// Assumes only the top ports; CTRL writes are snooped to learn the modes.
`timescale 1ns/10ps
`default_nettype none

module pio_ctrl_checker
  import pio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PIO_ADDR_W-1:0] paddr,
  input wire logic [PIO_DATA_W-1:0] pwdata,
  input wire logic trig_pin,
  input wire logic dir_pin,
  input wire logic motor_active_pin,
  input wire logic dir_out_pin,
  input wire logic prog_out_pin,
  input wire logic keypad_edit,
  input wire logic alarm,
  input wire logic pause_timer,
  input wire logic dir_key_ok,
  input wire logic program_run,
  input wire logic event_trap,
  input wire logic cond_jump
);
  // ****************************************************************
  // Bus snooping
  // ****************************************************************
  logic [4:0] ctrl_ff; // Trigger mode and direction mode last written
  logic wr_cmd, cond_req, out_req, out_lvl;
  assign wr_cmd = psel && penable && pwrite && paddr == PIO_OFS_CMD;
  assign cond_req = wr_cmd && pwdata[PIO_CMD_COND_BIT];
  assign out_req = wr_cmd && pwdata[PIO_CMD_OUT_BIT];
  assign out_lvl = pwdata[PIO_CMD_OUTLVL_BIT];
  // Taken on the same edge as the block, so both agree on the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 5'h00;
    end else if (psel && penable && pwrite && paddr == PIO_OFS_CTRL) begin
      ctrl_ff <= pwdata[4:0];
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Trigger held low with nothing else able to act during sync and detect
  sequence quiet_low_s;
    !trig_pin && !keypad_edit && !alarm && !psel;
  endsequence
  sequence foot_fall_s;
    ctrl_ff[3:0] == PIO_TRIG_FOOT && $fell(trig_pin) ##1 quiet_low_s [*2];
  endsequence
  foot_toggle_a: assert property (foot_fall_s |=> program_run != $past(program_run))
    else $error("foot switch fall did not toggle the program");
  start_hold_a: assert property (ctrl_ff[3:0] == PIO_TRIG_START && program_run && !psel
    |=> program_run) else $error("start only mode stopped the program");
  stop_hold_a: assert property (ctrl_ff[3:0] == PIO_TRIG_STOP && !program_run && !psel
    |=> !program_run) else $error("stop only mode started the program");
  ignore_a: assert property ((keypad_edit || alarm) && !psel
    |=> $stable(program_run) && $stable(dir_out_pin)) else $error("pin acted while ignored");
  motor_on_a: assert property (program_run && $past(program_run) && !pause_timer
    && !$past(pause_timer) |-> motor_active_pin) else $error("motor low while pumping");
  motor_low_a: assert property (motor_active_pin |-> program_run)
    else $error("motor high while program stopped");
  dir_cause_a: assert property ($changed(dir_out_pin) |-> $past(psel) ||
    $past(dir_key_ok) && $past(dir_pin, 3) != $past(dir_pin, 4))
    else $error("direction changed without cause");
  dir_sense_a: assert property ($changed(dir_out_pin) && !$past(psel)
    |-> dir_out_pin == ($past(dir_pin, 3) ^ !ctrl_ff[4])) else $error("direction set wrong way");
  trap_a: assert property (event_trap |-> ctrl_ff[3:0] == PIO_TRIG_EVENT_TRAP ||
    ctrl_ff[3:0] == PIO_TRIG_BUTTON_EVENT) else $error("trap outside the trap modes");
  jump_a: assert property (cond_jump |-> $past(cond_req))
    else $error("jump without a conditional step");
  out_a: assert property ($changed(prog_out_pin) |-> $past(out_req) &&
    prog_out_pin == $past(out_lvl)) else $error("program output set without a step");
endmodule

bind pio_ctrl pio_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .trig_pin, .dir_pin, .motor_active_pin, .dir_out_pin, .prog_out_pin,
  .keypad_edit, .alarm, .pause_timer, .dir_key_ok, .program_run, .event_trap, .cond_jump);
`default_nettype wire

// *** dv/pio_pin_model.sv ***
// Far side of the pins: foot switch, limit switch, timer or second pump.
// Assumes the bench asks for levels; contacts idle high on pull-ups.
`timescale 1ns/10ps
`default_nettype none

module pio_pin_model (
  input wire logic pclk,
  input wire logic [2:0] want,
  output logic trig_pin,
  output logic dir_pin,
  output logic prog_in_pin
);
  // Pins are unknown only until the first edge, while reset still holds
  // the synchroniser at the idle high level
  // A contact moves just after an edge and then stays put
  always @(posedge pclk) {trig_pin, dir_pin, prog_in_pin} <= want;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the pump logic I/O control block.
// Assumes the package, design, pin model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
  import pio_pkg::*;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] want; // Trigger, direction and program input levels
  logic trig_pin, dir_pin, prog_in_pin, motor_active_pin, dir_out_pin, prog_out_pin;
  logic keypad_edit, alarm, pause_timer, dir_key_ok, program_run, event_trap, cond_jump;
  logic [3:0] tbl [16]; // Run after fall, rise: from stopped, then running
  int n_fail, n_checks, m, s;
  pio_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trig_pin, .dir_pin, .prog_in_pin, .motor_active_pin, .dir_out_pin,
    .prog_out_pin, .keypad_edit, .alarm, .pause_timer, .dir_key_ok, .program_run,
    .event_trap, .cond_jump);
  pio_pin_model u_far (.pclk, .want, .trig_pin, .dir_pin, .prog_in_pin);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One transfer; the wait is bounded so a dead slave cannot hang the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin n_fail++; end_of_test; end
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task rst;
    @(posedge pclk); presetn <= 1'b0;
    repeat (4) @(posedge pclk); presetn <= 1'b1;
  endtask
  // Pins moved, then left long enough for sync, detect and update
  task pins(input logic [2:0] v);
    @(posedge pclk); want <= v;
    repeat (7) @(posedge pclk);
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0; want = 3'b111;
    keypad_edit = 0; alarm = 0; pause_timer = 0; dir_key_ok = 1; n_fail = 0; n_checks = 0;
    tbl = '{4'h3, 4'hC, 4'hA, 4'h6, 4'h5, 4'hF, 4'h7, 4'h0, 4'h2, 4'hA, 4'h5, 4'h0, 4'h0,
      4'hF, 4'h3, 4'h3};
    rst;
    apb(1'b0, PIO_OFS_STATUS, 32'h0); `CHK("status", 32'h0000_00E2, rd)
    apb(1'b1, 8'h0C, 32'hFF); `CHK("slverr", 1'b1, er)
    $display("test registers done");
    // Every trigger mode, from stopped and from running
    for (m = 0; m < 16; m++) for (s = 0; s < 2; s++) begin
      rst;
      if (s) apb(1'b1, PIO_OFS_CMD, 32'h1);
      apb(1'b1, PIO_OFS_CTRL, 32'(m));
      pins(3'b011); `CHK("run fall", tbl[m][3-2*s], program_run)
      pins(3'b111); `CHK("run rise", tbl[m][2-2*s], program_run)
      apb(1'b0, PIO_OFS_STATUS, 32'h0); `CHK("trap", (m == 13 && s == 1), rd[3])
    end
    $display("test trigger modes done");
    rst;
    for (m = 0; m < 6; m++) begin
      if (m == 3) apb(1'b1, PIO_OFS_CTRL, 32'h10);
      pins({1'b1, m[0], 1'b1}); `CHK("dir", 6'b101101 >> (5 - m) & 1, dir_out_pin)
    end
    dir_key_ok <= 1'b0;
    pins(3'b101); `CHK("dir key", 1'b1, dir_out_pin)
    dir_key_ok <= 1'b1;
    apb(1'b1, PIO_OFS_CTRL, 32'h11);
    keypad_edit <= 1'b1;
    pins(3'b011); `CHK("edit run", 1'b0, program_run)
    keypad_edit <= 1'b0;
    alarm <= 1'b1;
    pins(3'b101); `CHK("alarm dir", 1'b1, dir_out_pin)
    alarm <= 1'b0;
    pins(3'b001); `CHK("run", 1'b1, program_run)
    apb(1'b1, PIO_OFS_CMD, 32'h4); `CHK("dir key cmd", 1'b0, dir_out_pin)
    $display("test direction and ignore done");
    pause_timer <= 1'b1;
    apb(1'b1, PIO_OFS_CTRL, 32'h11); `CHK("motor opt0", 1'b0, motor_active_pin)
    apb(1'b1, PIO_OFS_CTRL, 32'h31); `CHK("motor opt1", 1'b1, motor_active_pin)
    apb(1'b1, PIO_OFS_CTRL, 32'h3E);
    apb(1'b1, PIO_OFS_CMD, 32'h2); `CHK("button run", 1'b1, program_run)
    apb(1'b0, PIO_OFS_STATUS, 32'h0); `CHK("button trap", 1'b1, rd[3])
    apb(1'b1, PIO_OFS_CMD, 32'h30); `CHK("prog out", 1'b1, prog_out_pin)
    pins(3'b000);
    apb(1'b1, PIO_OFS_CMD, 32'h8);
    apb(1'b0, PIO_OFS_STATUS, 32'h0); `CHK("jump low", 1'b1, rd[4])
    apb(1'b1, PIO_OFS_STATUS, 32'h10);
    pins(3'b001);
    apb(1'b1, PIO_OFS_CMD, 32'h8);
    apb(1'b0, PIO_OFS_STATUS, 32'h0); `CHK("jump high", 1'b0, rd[4])
    $display("test motor and program pins done");
    end_of_test;
  end
endmodule
`default_nettype wire
